//--- dv/aecsn_regs_tb.sv
// Self-checking testbench for the error-report and serial-number bank.
`timescale 1ns/10ps
module aecsn_regs_tb;

  // ****************************************
  // Signals
  // ****************************************
  logic                     pclk;
  logic                     presetn;
  logic                     hot_reset;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic                     pready;
  logic                     pslverr;
  logic [31:0]              prdata;
  logic                     sbe_detect;
  aecsn_pkg::aecsn_unc_type unc_err;
  logic                     sbe_report;
  logic                     sbe_status_set;
  logic                     crc_gen_en;
  logic                     crc_check_en;
  logic                     irq;
  int                       n_mismatch;
  int                       samples_checked;
  logic [31:0]              rd;
  logic                     err;
  logic [31:0]              sn_lo;
  logic [31:0]              sn_hi;
  logic [127:0]             exp_hdr;
  logic [4:0]               exp_pos;
  logic                     empty;

  aecsn_regs #(.AW(12)) i_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .hot_reset      (hot_reset),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .prdata         (prdata),
    .sbe_detect     (sbe_detect),
    .unc_err        (unc_err),
    .sbe_report     (sbe_report),
    .sbe_status_set (sbe_status_set),
    .crc_gen_en     (crc_gen_en),
    .crc_check_en   (crc_check_en),
    .irq            (irq)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The master never assumes a latency; only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  // Expected report and status pulses, given as {report, status}.
  task automatic sbe_pulse(input logic [1:0] exp);
    @(posedge pclk);
    sbe_detect <= 1'b1;
    @(posedge pclk);
    sbe_detect <= 1'b0;
    #1;
    chk("sbe_report", {31'h0, sbe_report}, {31'h0, exp[1]});
    chk("sbe_status", {31'h0, sbe_status_set}, {31'h0, exp[0]});
  endtask

  task automatic unc_pulse(input logic emp);
    logic [127:0] h;
    logic [4:0]   p;
    h = {$urandom, $urandom, $urandom, $urandom};
    p = 5'($urandom);
    if (emp) begin
      exp_hdr = h;
      exp_pos = p;
    end
    @(posedge pclk);
    unc_err <= '{valid:1'b1, status_empty:emp, bit_pos:p, header:h};
    @(posedge pclk);
    unc_err.valid <= 1'b0;
  endtask

  function automatic logic [31:0] ctl_val(logic [4:0] fe, logic gc,
                                          logic ge, logic cc, logic ce);
    return {23'h00_0000, ce, cc, ge, gc, fe};
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    hot_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sbe_detect = 1'b0;
    unc_err = '0;
    n_mismatch = 0;
    samples_checked = 0;
    exp_hdr = '0;
    exp_pos = 5'h00;
    void'($urandom(32'hAEF2));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(5'h00, 1, 0, 1, 0));
    rdchk("cap", aecsn_pkg::OFS_SNCAP, 32'h0001_0003);
    rdchk("sn_lo", aecsn_pkg::OFS_SNLO, 32'h0000_0000);
    rdchk("sn_hi", aecsn_pkg::OFS_SNHI, 32'h0000_0000);
    $display("test reset_values done");
    apb(1'b1, aecsn_pkg::OFS_CTL, 32'hFFFF_FFFF);
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(5'h00, 1, 1, 1, 1));
    chk("gen_en", {31'h0, crc_gen_en}, 32'h0000_0001);
    chk("chk_en", {31'h0, crc_check_en}, 32'h0000_0001);
    apb(1'b1, aecsn_pkg::OFS_CTL, 32'h0000_0000);
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(5'h00, 0, 0, 0, 0));
    sn_lo = $urandom;
    sn_hi = $urandom;
    apb(1'b1, aecsn_pkg::OFS_SNLO, sn_lo);
    apb(1'b1, aecsn_pkg::OFS_SNHI, sn_hi);
    apb(1'b1, aecsn_pkg::OFS_SNCAP, 32'hFFFF_FFFF);
    rdchk("sn_lo", aecsn_pkg::OFS_SNLO, sn_lo);
    rdchk("sn_hi", aecsn_pkg::OFS_SNHI, sn_hi);
    rdchk("cap", aecsn_pkg::OFS_SNCAP, 32'hFFF1_0003);
    // Locked: capability bits, pointer and low serial half hold.
    apb(1'b1, aecsn_pkg::OFS_UNLOCK, 32'h0000_0000);
    apb(1'b1, aecsn_pkg::OFS_CTL, 32'h0000_01E0);
    apb(1'b1, aecsn_pkg::OFS_SNLO, ~sn_lo);
    apb(1'b1, aecsn_pkg::OFS_SNCAP, 32'h0000_0000);
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(5'h00, 0, 1, 0, 1));
    rdchk("sn_lo", aecsn_pkg::OFS_SNLO, sn_lo);
    rdchk("cap", aecsn_pkg::OFS_SNCAP, 32'hFFF1_0003);
    $display("test control_lock done");
    apb(1'b1, aecsn_pkg::OFS_CMASK, 32'h8000_0000);
    rdchk("mask", aecsn_pkg::OFS_CMASK, 32'h0000_0000);
    sbe_pulse(2'b00);
    apb(1'b1, aecsn_pkg::OFS_MEMORY_ERROR_CONTROL, 32'h0000_0001);
    apb(1'b1, aecsn_pkg::OFS_CMASK, 32'h8000_0000);
    rdchk("mask", aecsn_pkg::OFS_CMASK, 32'h8000_0000);
    apb(1'b1, aecsn_pkg::OFS_IMSK, 32'h0000_0001);
    sbe_pulse(2'b01);
    apb(1'b1, aecsn_pkg::OFS_CMASK, 32'h0000_0000);
    sbe_pulse(2'b11);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, aecsn_pkg::OFS_IMSK, 32'h0000_0003);
    #1;
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    rdchk("ists", aecsn_pkg::OFS_ISTS, 32'h0000_0002);
    @(posedge pclk);
    #1;
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test single_bit done");
    // Only a capture while the outside status is empty may log.
    unc_pulse(1'b1);
    repeat (4) begin
      empty = 1'($urandom);
      unc_pulse(empty);
    end
    unc_pulse(1'b0);
    for (int i = 0; i < 4; i++)
      rdchk("hl", 12'(aecsn_pkg::OFS_HL1 + 4*i), exp_hdr[32*i+:32]);
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(exp_pos, 0, 1, 0, 1));
    apb(1'b1, aecsn_pkg::OFS_HL1, ~exp_hdr[31:0]);
    rdchk("hl1", aecsn_pkg::OFS_HL1, exp_hdr[31:0]);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, 12'h3F0, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    $display("test header_log done");
    @(posedge pclk);
    hot_reset <= 1'b1;
    @(posedge pclk);
    hot_reset <= 1'b0;
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(exp_pos, 1, 1, 1, 1));
    rdchk("cap", aecsn_pkg::OFS_SNCAP, 32'h0001_0003);
    rdchk("sn_hi", aecsn_pkg::OFS_SNHI, sn_hi);
    rdchk("hl4", aecsn_pkg::OFS_HL4, exp_hdr[127:96]);
    rdchk("imsk", aecsn_pkg::OFS_IMSK, 32'h0000_0000);
    rdchk("memory_error_control", aecsn_pkg::OFS_MEMORY_ERROR_CONTROL, 32'h0000_0000);
    rdchk("unlock", aecsn_pkg::OFS_UNLOCK, 32'h0000_0001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctl", aecsn_pkg::OFS_CTL, ctl_val(5'h00, 1, 0, 1, 0));
    rdchk("sn_lo", aecsn_pkg::OFS_SNLO, 32'h0000_0000);
    $display("test resets done");
    close_out();
  end

endmodule

//--- hw/aecsn_pkg.sv
// Shared constants and types for the error-report and serial-number bank.
package aecsn_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_CMASK  = 12'h114;
  localparam logic [11:0] OFS_CTL    = 12'h118;
  localparam logic [11:0] OFS_HL1    = 12'h11C;
  localparam logic [11:0] OFS_HL2    = 12'h120;
  localparam logic [11:0] OFS_HL3    = 12'h124;
  localparam logic [11:0] OFS_HL4    = 12'h128;
  localparam logic [11:0] OFS_SNCAP  = 12'h180;
  localparam logic [11:0] OFS_SNLO   = 12'h184;
  localparam logic [11:0] OFS_SNHI   = 12'h188;
  localparam logic [11:0] OFS_MEMORY_ERROR_CONTROL  = 12'h190;
  localparam logic [11:0] OFS_ISTS   = 12'h194;
  localparam logic [11:0] OFS_IMSK   = 12'h198;
  localparam logic [11:0] OFS_UNLOCK = 12'h19C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SBE_MASK_BIT  = 31;
  localparam int GEN_CAP_BIT   = 5;
  localparam int GEN_EN_BIT    = 6;
  localparam int CHK_CAP_BIT   = 7;
  localparam int CHK_EN_BIT    = 8;
  localparam int NXT_LSB       = 20;
  localparam int VER_LSB       = 16;
  localparam int IRQ_UNC_BIT   = 0;
  localparam int IRQ_SBE_BIT   = 1;

  // ****************************************
  // Values after reset and fixed values
  // ****************************************
  localparam logic [15:0] CAP_ID_VAL   = 16'h0003;
  localparam logic [3:0]  CAP_VER_VAL  = 4'h1;
  localparam logic [11:0] NXT_RST      = 12'h000;
  localparam logic        GEN_CAP_RST  = 1'b1;
  localparam logic        CHK_CAP_RST  = 1'b1;
  localparam logic        UNLOCK_RST   = 1'b1;
  localparam logic [4:0]  FIRST_ERROR_POINTER_RST    = 5'h00;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;

  // ****************************************
  // State of the bank
  // ****************************************
  typedef struct packed {
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
    logic             sbe_report;
    logic             sbe_status_set;
    logic             sbe_en;
    logic             unlock;
    logic [1:0]       ists;
    logic [1:0]       imsk;
    logic             mask_sbe;
    logic [4:0]       fe_ptr;
    logic             gen_cap;
    logic             gen_en;
    logic             chk_cap;
    logic             chk_en;
    logic [3:0][31:0] hl;
    logic [11:0]      nxt_ptr;
    logic [31:0]      sn_lo;
    logic [31:0]      sn_hi;
  } aecsn_state_type;

  typedef struct packed {
    logic         valid;
    logic         status_empty;
    logic [4:0]   bit_pos;
    logic [127:0] header;
  } aecsn_unc_type;

endpackage

//--- hw/aecsn_regs.sv
// Error-report control, header log and serial-number register bank.
// Operation
// - A masked single-bit error is not logged, pointed at or reported.
// - The mask never stops the status bit from recording the error.
// - With reporting off, the mask bit reads zero and ignores writes.
// - A sticky read-only pointer, zero at reset, marks the first error.
// - Control bit 5 shows generation capability, one at reset, lockable.
// - Bit 6 is a sticky enable, zero at reset, for CRC generation.
// - Control bit 7 shows check capability, one at reset, lockable.
// - Bit 8 is a sticky enable, zero at reset, for CRC checking.
// - Four read-only words log the first error's header, in order.
// - The serial header reads ID 3, version 1 and a lockable pointer.
// - The 64-bit serial number is two sticky lockable zeroed halves.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module aecsn_regs #(
  parameter int AW = 12
) (
  // Clock and resets
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    hot_reset,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [AW-1:0]           paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  // Error events from the port
  input  wire logic                    sbe_detect,
  input  wire aecsn_pkg::aecsn_unc_type unc_err,
  // Results
  output logic                         sbe_report,
  output logic                         sbe_status_set,
  output logic                         crc_gen_en,
  output logic                         crc_check_en,
  output logic                         irq
);

  // ****************************************
  // State
  // ****************************************
  aecsn_pkg::aecsn_state_type st_r;
  aecsn_pkg::aecsn_state_type st_nxt;

  logic            acc;
  logic            done;
  logic            wr;
  logic            rd;
  logic [11:0]     a;
  logic            mask_eff;
  logic            unc_take;
  logic [1:0]      ev;

  assign a        = paddr[11:0];
  assign acc      = psel & penable & ~st_r.pready;
  assign done     = psel & penable & st_r.pready;
  assign wr       = done & pwrite;
  assign rd       = done & ~pwrite;
  assign mask_eff = st_r.mask_sbe & st_r.sbe_en;
  assign unc_take = unc_err.valid & unc_err.status_empty;

  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic [32:0] rd_mux(
    input logic [11:0]                 ad,
    input aecsn_pkg::aecsn_state_type s
  );
    logic [32:0] r;
    r = {1'b0, aecsn_pkg::WORD_RST};
    case (ad)
      aecsn_pkg::OFS_CMASK: begin
        r[aecsn_pkg::SBE_MASK_BIT] = s.mask_sbe & s.sbe_en;
      end
      aecsn_pkg::OFS_CTL: begin
        r[4:0] = s.fe_ptr;
        r[aecsn_pkg::GEN_CAP_BIT] = s.gen_cap;
        r[aecsn_pkg::GEN_EN_BIT]  = s.gen_en;
        r[aecsn_pkg::CHK_CAP_BIT] = s.chk_cap;
        r[aecsn_pkg::CHK_EN_BIT]  = s.chk_en;
      end
      aecsn_pkg::OFS_HL1:   r[31:0] = s.hl[0];
      aecsn_pkg::OFS_HL2:   r[31:0] = s.hl[1];
      aecsn_pkg::OFS_HL3:   r[31:0] = s.hl[2];
      aecsn_pkg::OFS_HL4:   r[31:0] = s.hl[3];
      aecsn_pkg::OFS_SNCAP: begin
        r[31:0] = {s.nxt_ptr, aecsn_pkg::CAP_VER_VAL,
                   aecsn_pkg::CAP_ID_VAL};
      end
      aecsn_pkg::OFS_SNLO:   r[31:0] = s.sn_lo;
      aecsn_pkg::OFS_SNHI:   r[31:0] = s.sn_hi;
      aecsn_pkg::OFS_MEMORY_ERROR_CONTROL:  r[0]    = s.sbe_en;
      aecsn_pkg::OFS_ISTS:   r[1:0]  = s.ists;
      aecsn_pkg::OFS_IMSK:   r[1:0]  = s.imsk;
      aecsn_pkg::OFS_UNLOCK: r[0]    = s.unlock;
      default:               r[32]   = 1'b1;
    endcase
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [32:0] rv;
    rv     = rd_mux(a, st_r);
    st_nxt = st_r;
    ev     = 2'b00;

    // One wait state: the answer comes one edge into the access phase.
    st_nxt.pready = acc;
    if (acc) begin
      st_nxt.pslverr = rv[32];
      st_nxt.prdata  = pwrite ? aecsn_pkg::WORD_RST : rv[31:0];
    end else if (done) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = aecsn_pkg::WORD_RST;
    end

    st_nxt.sbe_report = sbe_detect & st_r.sbe_en & ~mask_eff;
    st_nxt.sbe_status_set = sbe_detect & st_r.sbe_en;
    ev[aecsn_pkg::IRQ_SBE_BIT] = st_nxt.sbe_report;

    // The log is taken only while the status register outside is
    // empty, so a later error cannot overwrite the first one.
    if (unc_take) begin
      st_nxt.fe_ptr = unc_err.bit_pos;
      for (int i = 0; i < 4; i++) begin
        st_nxt.hl[i] = unc_err.header[32*i +: 32];
      end
      ev[aecsn_pkg::IRQ_UNC_BIT] = 1'b1;
    end

    if (wr) begin
      case (a)
        aecsn_pkg::OFS_CMASK: begin
          if (st_r.sbe_en) begin
            st_nxt.mask_sbe = pwdata[aecsn_pkg::SBE_MASK_BIT];
          end
        end
        aecsn_pkg::OFS_CTL: begin
          st_nxt.gen_en = pwdata[aecsn_pkg::GEN_EN_BIT];
          st_nxt.chk_en = pwdata[aecsn_pkg::CHK_EN_BIT];
          if (st_r.unlock) begin
            st_nxt.gen_cap = pwdata[aecsn_pkg::GEN_CAP_BIT];
            st_nxt.chk_cap = pwdata[aecsn_pkg::CHK_CAP_BIT];
          end
        end
        aecsn_pkg::OFS_SNCAP: begin
          if (st_r.unlock) begin
            st_nxt.nxt_ptr = pwdata[31:aecsn_pkg::NXT_LSB];
          end
        end
        aecsn_pkg::OFS_SNLO: begin
          if (st_r.unlock) begin
            st_nxt.sn_lo = pwdata;
          end
        end
        aecsn_pkg::OFS_SNHI: begin
          if (st_r.unlock) begin
            st_nxt.sn_hi = pwdata;
          end
        end
        aecsn_pkg::OFS_MEMORY_ERROR_CONTROL:  st_nxt.sbe_en = pwdata[0];
        aecsn_pkg::OFS_IMSK:   st_nxt.imsk   = pwdata[1:0];
        aecsn_pkg::OFS_UNLOCK: st_nxt.unlock = pwdata[0];
        default: ;
      endcase
    end

    // A read clears only the bits that it returned, so an event that
    // lands after the data was taken survives; a new event wins unless hot_reset is high.
    if (rd && a == aecsn_pkg::OFS_ISTS) begin
      st_nxt.ists = (st_r.ists & ~st_r.prdata[1:0]) | ev;
    end else begin
      st_nxt.ists = st_r.ists | ev;
    end

    if (hot_reset) begin
      st_nxt.gen_cap    = aecsn_pkg::GEN_CAP_RST;
      st_nxt.chk_cap    = aecsn_pkg::CHK_CAP_RST;
      st_nxt.nxt_ptr    = aecsn_pkg::NXT_RST;
      st_nxt.unlock     = aecsn_pkg::UNLOCK_RST;
      st_nxt.sbe_en     = 1'b0;
      st_nxt.ists       = 2'b00;
      st_nxt.imsk       = 2'b00;
      st_nxt.sbe_report = 1'b0;
    end

    st_nxt.irq = |(st_nxt.ists & st_nxt.imsk);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.gen_cap <= aecsn_pkg::GEN_CAP_RST;
      st_r.chk_cap <= aecsn_pkg::CHK_CAP_RST;
      st_r.unlock  <= aecsn_pkg::UNLOCK_RST;
      st_r.nxt_ptr <= aecsn_pkg::NXT_RST;
      st_r.fe_ptr  <= aecsn_pkg::FIRST_ERROR_POINTER_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign prdata         = st_r.prdata;
  assign sbe_report     = st_r.sbe_report;
  assign sbe_status_set = st_r.sbe_status_set;
  assign crc_gen_en     = st_r.gen_en;
  assign crc_check_en   = st_r.chk_en;
  assign irq            = st_r.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ctl_wr;
    wr && a == aecsn_pkg::OFS_CTL && !hot_reset;
  endsequence

  sequence s_locked_ctl_wr;
    s_ctl_wr ##0 !st_r.unlock;
  endsequence

  sequence s_sbe_masked;
    sbe_detect && st_r.sbe_en && st_r.mask_sbe;
  endsequence

  a_sbe_masked_quiet: assert property (
    s_sbe_masked |=> !sbe_report
      && !$rose(st_r.ists[aecsn_pkg::IRQ_SBE_BIT]))
    else $error("masked single-bit error was reported");

  a_sbe_status_kept: assert property (
    sbe_detect && st_r.sbe_en |=> sbe_status_set)
    else $error("single-bit status set was lost");

  a_mask_read_zero: assert property (
    rd && a == aecsn_pkg::OFS_CMASK && !$past(st_r.sbe_en)
      |-> !prdata[aecsn_pkg::SBE_MASK_BIT])
    else $error("mask bit read as one while disabled");

  a_first_error_pointer_capture: assert property (
    unc_take |=> st_r.fe_ptr == $past(unc_err.bit_pos))
    else $error("first error pointer not captured");

  a_gen_cap_locked: assert property (
    s_locked_ctl_wr |=> $stable(st_r.gen_cap))
    else $error("generation capability changed while locked");

  a_gen_en_write: assert property (
    s_ctl_wr ##0 pwdata[aecsn_pkg::GEN_EN_BIT] |=> crc_gen_en [*2])
    else $error("generation enable did not follow write");

  a_chk_cap_locked: assert property (
    s_locked_ctl_wr |=> $stable(st_r.chk_cap))
    else $error("check capability changed while locked");

  a_chk_en_write: assert property (
    s_ctl_wr |=> crc_check_en == $past(pwdata[aecsn_pkg::CHK_EN_BIT]))
    else $error("check enable did not follow write");

  a_hdr_log_order: assert property (
    unc_take |=> st_r.hl[0] == $past(unc_err.header[31:0])
      && st_r.hl[3] == $past(unc_err.header[127:96]))
    else $error("header log words out of order");

  a_cap_header_id: assert property (
    rd && a == aecsn_pkg::OFS_SNCAP |-> prdata[19:0] == 20'h1_0003)
    else $error("capability header identifier wrong");

  a_serial_locked: assert property (
    wr && a == aecsn_pkg::OFS_SNLO && !st_r.unlock
      |=> $stable(st_r.sn_lo))
    else $error("serial word changed while locked");

  a_ctl_rsvd_zero: assert property (
    rd && a == aecsn_pkg::OFS_CTL |-> prdata[31:9] == 23'h000000)
    else $error("control reserved bits not zero");

  a_sticky_hot_keep: assert property (
    hot_reset && !wr && !unc_take |=> $stable(st_r.sn_hi)
      && $stable(st_r.fe_ptr) && $stable(st_r.gen_en))
    else $error("sticky field lost at hot reset");

  a_mask_wr_ignored: assert property (
    wr && a == aecsn_pkg::OFS_CMASK && !st_r.sbe_en
      |=> $stable(st_r.mask_sbe))
    else $error("mask bit written while reporting off");

  a_sbe_off_quiet: assert property (
    sbe_detect && !st_r.sbe_en |=> !sbe_report && !sbe_status_set)
    else $error("single-bit error acted on while reporting off");

  a_sbe_no_pointer: assert property (
    sbe_detect && !unc_take |=> $stable(st_r.fe_ptr))
    else $error("single-bit error moved the first error pointer");

  a_hdr_log_held: assert property (
    !unc_take |=> $stable(st_r.hl))
    else $error("header log changed without a logged error");

  a_sbe_irq_status: assert property (
    sbe_report |-> st_r.ists[aecsn_pkg::IRQ_SBE_BIT])
    else $error("reported single-bit error left no status");

  a_log_irq_status: assert property (
    unc_take && !hot_reset |=> st_r.ists[aecsn_pkg::IRQ_UNC_BIT])
    else $error("logged header left no status");

  a_apb_one_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("slave answer timing broken");

endmodule
